/* lsp_device.sv */
`timescale 1ns/100ps
// Function
// [RQ1] Act only on 8, 16, 24 bit frames
// [RQ2] Sample data on clock rise while selected
// [RQ3] Last eight bits are the data byte
// [RQ4] Leading bit set means read, else write
// [RQ5] 8-bit write at display pointer, then increment
// [RQ6] Decode 16-bit frame as register access
// [RQ7] Host never sets bit 12 in 16-bit
// [RQ8] Global writes all, local writes pointed device
// [RQ9] Only pointed device answers a 16-bit read
// [RQ10] Driver pointer increments when flag set; the code does not increment it on 16-bit global writes
// [RQ11] 24-bit frame addresses memory directly
// [RQ12] Address splits into plane and location
// [RQ13] Read: frame, deselect, then clock eight bits
// [RQ14] Output released except during read-back
// [RQ15] Release after eighth falling clock edge
// [RQ16] Select falling aborts read-back at once
// [RQ17] Host: clock low, select low, MSB first
// [RQ18] At most 256 devices on the bus
// [RQ19] Host raises select while clock high
// [RQ20] Dummy data bits ignored in reads
// [RQ21] Global register reads answered by position zero
// [RQ22] Counter clears on select fall, act on rise
module lsp_device (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Serial link
    lsp_link_if.dev link,
    // Position from the address allocation bus
    input wire logic [7:0] pos_i,
    // Register write notification
    output logic cfg_wr_o,
    output logic [3:0] cfg_addr_o,
    output logic [7:0] cfg_data_o,
    // Display pointer
    output logic [13:0] disp_ptr_o
);
    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic logic [6:0] own_idx(input logic [13:0] a, input logic two_bpp,
                                           input logic [7:0] pos);
        logic [6:0] r;
        r = 7'h00;
        if (two_bpp) begin // [RQ12]
            r = {a[12:5] == pos, a[13], a[4:0]};
        end else begin
            r = {a[11:4] == pos, a[13:12], a[3:0]};
        end
        return r;
    endfunction : own_idx

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [2:0] sync1, sync2, prev;
    logic [2:0] next_sync1, next_sync2, next_prev;
    logic cs_fall, cs_rise, ck_rise, ck_fall, cs_low;

    always_comb begin
        next_sync1 = {link.cs_n, link.sclk, link.din};
        next_sync2 = sync1;
        next_prev = sync2;
        cs_low = ~sync2[2];
        cs_fall = ~sync2[2] & prev[2];
        cs_rise = sync2[2] & ~prev[2];
        ck_rise = sync2[1] & ~prev[1];
        ck_fall = ~sync2[1] & prev[1];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1 <= 3'h4;
            sync2 <= 3'h4;
            prev <= 3'h4;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            prev <= next_prev;
        end
    end

    // ************************************************************
    // Frame receiver
    // ************************************************************
    logic [23:0] shreg, next_shreg;
    logic [4:0] bitcnt, next_bitcnt;

    always_comb begin
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        if (cs_fall) begin
            next_bitcnt = 5'h00; // [RQ22]
        end
        if (cs_low && ck_rise) begin // [RQ2]
            next_shreg = {shreg[22:0], sync2[0]};
            if (next_bitcnt != lsp_pkg::LEN_SAT) begin
                next_bitcnt = next_bitcnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shreg <= 24'h000000;
            bitcnt <= 5'h00;
        end else begin
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
        end
    end

    // ************************************************************
    // Frame execution and storage
    // ************************************************************
    logic [7:0] regs [0:15];
    logic [7:0] mem [0:lsp_pkg::MEM_DEPTH-1];
    logic [7:0] drv_ptr, next_drv_ptr;
    logic [13:0] dptr, next_dptr;
    logic reg_we, mem_we, rb_load;
    logic [3:0] reg_wa;
    logic [5:0] mem_wa;
    logic [7:0] wdata, rb_value;
    logic [6:0] hit8, hit24;
    logic [3:0] ra;
    logic two_bpp, sel_me, answer;
    logic next_cfg_wr;

    always_comb begin
        reg_we = 1'b0;
        mem_we = 1'b0;
        rb_load = 1'b0;
        rb_value = 8'h00;
        reg_wa = shreg[lsp_pkg::RA_LSB +: 4];
        ra = shreg[lsp_pkg::RA_LSB +: 4];
        mem_wa = 6'h00;
        wdata = shreg[7:0]; // [RQ3]
        next_drv_ptr = drv_ptr;
        next_dptr = dptr;
        next_cfg_wr = 1'b0;
        answer = 1'b0;
        two_bpp = regs[lsp_pkg::REG_PANEL_CFG][lsp_pkg::PANEL_TWO_BPP_BIT];
        sel_me = (pos_i == drv_ptr);
        hit8 = own_idx(dptr, two_bpp, pos_i);
        hit24 = own_idx(shreg[lsp_pkg::ADDR24_LSB +: lsp_pkg::ADDR_W], two_bpp, pos_i);
        if (cs_rise) begin // [RQ22]
            if (bitcnt == lsp_pkg::LEN8) begin // [RQ1]
                mem_we = hit8[6]; // [RQ5]
                mem_wa = hit8[5:0];
                next_dptr = dptr + 14'h0001; // [RQ5]
            end else if (bitcnt == lsp_pkg::LEN16 && !shreg[lsp_pkg::RSV_BIT]) begin // [RQ6] [RQ7]
                if (shreg[lsp_pkg::RW16_BIT]) begin // [RQ4]
                    answer = ra[3] ? (pos_i == 8'h00) : sel_me; // [RQ9] [RQ21]
                    rb_load = answer;
                    case (ra)
                        lsp_pkg::REG_POS: rb_value = pos_i;
                        lsp_pkg::REG_DRV_PTR: rb_value = drv_ptr;
                        lsp_pkg::REG_DISP_PTR_LO: rb_value = dptr[7:0];
                        lsp_pkg::REG_DISP_PTR_HI: rb_value = {2'h0, dptr[13:8]};
                        default: rb_value = regs[ra];
                    endcase
                end else if (shreg[lsp_pkg::GLB_BIT] || sel_me) begin // [RQ8]
                    next_cfg_wr = 1'b1;
                    case (ra)
                        lsp_pkg::REG_POS: next_cfg_wr = 1'b0;
                        lsp_pkg::REG_DRV_PTR: next_drv_ptr = wdata;
                        lsp_pkg::REG_DISP_PTR_LO: next_dptr = {dptr[13:8], wdata};
                        lsp_pkg::REG_DISP_PTR_HI: next_dptr = {wdata[5:0], dptr[7:0]};
                        default: reg_we = 1'b1;
                    endcase
                end
                if (shreg[lsp_pkg::AUTOINC_BIT]
                    && (shreg[lsp_pkg::RW16_BIT] || !shreg[lsp_pkg::GLB_BIT])) begin
                    next_drv_ptr = next_drv_ptr + 8'h01; // [RQ10]
                end
            end else if (bitcnt == lsp_pkg::LEN24) begin // [RQ11]
                if (shreg[lsp_pkg::RW24_BIT]) begin // [RQ4] [RQ20]
                    rb_load = hit24[6];
                    rb_value = mem[hit24[5:0]];
                end else begin
                    mem_we = hit24[6];
                    mem_wa = hit24[5:0];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 16; i++) begin
                regs[i] <= lsp_pkg::REG_RESET;
            end
            drv_ptr <= 8'h00;
            dptr <= 14'h0000;
            cfg_wr_o <= 1'b0;
            cfg_addr_o <= 4'h0;
            cfg_data_o <= 8'h00;
        end else begin
            if (reg_we) begin
                regs[reg_wa] <= wdata;
            end
            if (mem_we) begin
                mem[mem_wa] <= wdata;
            end
            drv_ptr <= next_drv_ptr;
            dptr <= next_dptr;
            cfg_wr_o <= next_cfg_wr;
            if (next_cfg_wr) begin
                cfg_addr_o <= reg_wa;
                cfg_data_o <= wdata;
            end
        end
    end

    assign disp_ptr_o = dptr;

    // ************************************************************
    // Read-back shifter
    // ************************************************************
    logic [7:0] rb_shift, next_rb_shift;
    logic [3:0] rb_cnt, next_rb_cnt;
    logic rb_rise, next_rb_rise;
    logic dout_q, next_dout_q, oe_q, next_oe_q;

    always_comb begin
        next_rb_shift = rb_shift;
        next_rb_cnt = rb_cnt;
        next_rb_rise = rb_rise;
        next_dout_q = dout_q;
        next_oe_q = oe_q;
        if (rb_load) begin // [RQ13]
            next_rb_shift = rb_value;
            next_rb_cnt = 4'h0;
            next_rb_rise = 1'b0;
            next_dout_q = rb_value[7];
            next_oe_q = 1'b1;
        end else if (oe_q) begin
            if (cs_fall) begin
                next_oe_q = 1'b0; // [RQ16]
            end else if (ck_rise) begin
                next_rb_rise = 1'b1;
            end else if (ck_fall && rb_rise) begin
                next_rb_cnt = rb_cnt + 4'h1;
                next_rb_shift = {rb_shift[6:0], 1'b0};
                next_dout_q = rb_shift[6]; // [RQ14]
                if (rb_cnt == 4'h7) begin
                    next_oe_q = 1'b0; // [RQ15]
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rb_shift <= 8'h00;
            rb_cnt <= 4'h0;
            rb_rise <= 1'b0;
            dout_q <= 1'b0;
            oe_q <= 1'b0; // [RQ14]
        end else begin
            rb_shift <= next_rb_shift;
            rb_cnt <= next_rb_cnt;
            rb_rise <= next_rb_rise;
            dout_q <= next_dout_q;
            oe_q <= next_oe_q;
        end
    end

    assign link.dout_drv = dout_q;
    assign link.dout_oe = oe_q;
endmodule : lsp_device

/* lsp_pkg.sv */
package lsp_pkg;
    // ************************************************************
    // Frame format
    // ************************************************************
    localparam logic [4:0] LEN8 = 5'h08;
    localparam logic [4:0] LEN16 = 5'h10;
    localparam logic [4:0] LEN24 = 5'h18;
    localparam logic [4:0] LEN_SAT = 5'h19;
    localparam int RW16_BIT = 15;
    localparam int AUTOINC_BIT = 14;
    localparam int GLB_BIT = 13;
    localparam int RSV_BIT = 12;
    localparam int RA_LSB = 8;
    localparam int RW24_BIT = 23;
    localparam int ADDR24_LSB = 8;
    localparam int ADDR_W = 14;
    // ************************************************************
    // Device register file
    // ************************************************************
    localparam logic [3:0] REG_POS = 4'h0;
    localparam logic [3:0] REG_DRV_PTR = 4'h8;
    localparam logic [3:0] REG_DISP_PTR_LO = 4'h9;
    localparam logic [3:0] REG_DISP_PTR_HI = 4'hA;
    localparam logic [3:0] REG_PANEL_CFG = 4'hD;
    localparam int PANEL_TWO_BPP_BIT = 1;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int MEM_DEPTH = 64;
    // ************************************************************
    // Host controller registers (Wishbone byte offsets)
    // ************************************************************
    localparam logic [7:0] HOST_FRAME = 8'h00;
    localparam logic [7:0] HOST_CTRL = 8'h04;
    localparam logic [7:0] HOST_STATUS = 8'h08;
    localparam int CTRL_LEN_LSB = 0;
    localparam int CTRL_RD_BIT = 4;
    localparam int CTRL_GO_BIT = 8;
    localparam int STAT_RX_LSB = 8;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_NS = 100;
    localparam int HALF_NS = 400;
    localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
    // ************************************************************
    // Host sequencer states
    // ************************************************************
    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_SEL = 3'h1,
        H_LOW = 3'h2,
        H_HIGH = 3'h3,
        H_END = 3'h4,
        H_TAIL = 3'h5,
        H_RLOW = 3'h6,
        H_RHIGH = 3'h7
    } lsp_hstate_type;
endpackage : lsp_pkg

/* lsp_link_if.sv */
`timescale 1ns/100ps
interface lsp_link_if;
    logic cs_n;
    logic sclk;
    logic din;
    logic dout_drv;
    logic dout_oe;
    logic dout_line;
    // Pulled high while no device drives the read line
    assign dout_line = dout_oe ? dout_drv : 1'b1;
    modport host (output cs_n, output sclk, output din, input dout_line);
    modport dev (input cs_n, input sclk, input din, output dout_drv, output dout_oe);
endinterface : lsp_link_if

/* lsp_host.sv */
`timescale 1ns/100ps
module lsp_host (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial link
    lsp_link_if.host link
);
    // ************************************************************
    // Bus slave and registers
    // ************************************************************
    logic [23:0] frame, next_frame;
    logic [1:0] len_code, next_len_code;
    logic rd_mode, next_rd_mode;
    logic [7:0] rx, next_rx;
    logic busy;
    logic next_ack;
    logic [31:0] next_dat;
    logic go;

    always_comb begin
        next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        next_dat = wb_dat_o;
        next_frame = frame;
        next_len_code = len_code;
        next_rd_mode = rd_mode;
        go = 1'b0;
        if (next_ack) begin
            case (wb_adr_i)
                lsp_pkg::HOST_FRAME: next_dat = {8'h00, frame};
                lsp_pkg::HOST_CTRL: next_dat = {27'h0, rd_mode, 2'h0, len_code};
                lsp_pkg::HOST_STATUS: next_dat = {16'h0000, rx, 7'h00, busy};
                default: next_dat = 32'h00000000;
            endcase
        end
        if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i) begin
            if (wb_adr_i == lsp_pkg::HOST_FRAME) begin
                for (int b = 0; b < 3; b++) begin
                    if (wb_sel_i[b]) begin
                        next_frame[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                    end
                end
            end else if (wb_adr_i == lsp_pkg::HOST_CTRL && wb_sel_i[0] && !busy) begin
                next_len_code = wb_dat_i[lsp_pkg::CTRL_LEN_LSB +: 2];
                next_rd_mode = wb_dat_i[lsp_pkg::CTRL_RD_BIT];
                go = wb_sel_i[1] && wb_dat_i[lsp_pkg::CTRL_GO_BIT]
                     && wb_dat_i[lsp_pkg::CTRL_LEN_LSB +: 2] != 2'h0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            frame <= 24'h000000;
            len_code <= 2'h0;
            rd_mode <= 1'b0;
        end else begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
            frame <= next_frame;
            len_code <= next_len_code;
            rd_mode <= next_rd_mode;
        end
    end

    // ************************************************************
    // Half-period divider and read-line synchroniser
    // ************************************************************
    logic [7:0] div, next_div;
    logic tick;
    logic dsync1, dsync2;

    always_comb begin
        tick = (div == 8'(lsp_pkg::HALF_CYC - 1));
        next_div = tick ? 8'h00 : div + 8'h01;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div <= 8'h00;
            dsync1 <= 1'b1;
            dsync2 <= 1'b1;
        end else begin
            div <= next_div;
            dsync1 <= link.dout_line;
            dsync2 <= dsync1;
        end
    end

    // ************************************************************
    // Link sequencer
    // ************************************************************
    lsp_pkg::lsp_hstate_type st, next_st;
    logic [23:0] sh, next_sh;
    logic [4:0] left, next_left;
    logic cs_q, next_cs_q, ck_q, next_ck_q, din_q, next_din_q;

    always_comb begin
        next_st = st;
        next_sh = sh;
        next_left = left;
        next_cs_q = cs_q;
        next_ck_q = ck_q;
        next_din_q = din_q;
        next_rx = rx;
        busy = (st != lsp_pkg::H_IDLE);
        case (st)
            lsp_pkg::H_IDLE: begin
                if (go) begin
                    next_sh = frame << (5'h18 - {next_len_code, 3'h0});
                    next_left = {next_len_code, 3'h0};
                    next_ck_q = 1'b0; // [RQ17]
                    next_st = lsp_pkg::H_SEL;
                end
            end
            lsp_pkg::H_SEL: begin
                next_cs_q = 1'b0; // [RQ17]
                if (tick) begin
                    next_din_q = sh[23];
                    next_sh = {sh[22:0], 1'b0};
                    next_st = lsp_pkg::H_LOW;
                end
            end
            lsp_pkg::H_LOW: begin
                if (tick) begin
                    next_ck_q = 1'b1; // [RQ2]
                    next_st = lsp_pkg::H_HIGH;
                end
            end
            lsp_pkg::H_HIGH: begin
                if (tick) begin
                    next_left = left - 5'h01;
                    if (left == 5'h01) begin
                        next_cs_q = 1'b1; // [RQ19]
                        next_st = lsp_pkg::H_END;
                    end else begin
                        next_ck_q = 1'b0;
                        next_din_q = sh[23];
                        next_sh = {sh[22:0], 1'b0};
                        next_st = lsp_pkg::H_LOW;
                    end
                end
            end
            lsp_pkg::H_END: begin
                if (tick) begin
                    next_ck_q = 1'b0; // [RQ19]
                    next_st = lsp_pkg::H_TAIL;
                end
            end
            lsp_pkg::H_TAIL: begin
                if (tick) begin
                    next_left = 5'h08;
                    next_st = (rd_mode && len_code != 2'h1) ? lsp_pkg::H_RLOW : lsp_pkg::H_IDLE;
                end
            end
            lsp_pkg::H_RLOW: begin
                if (tick) begin
                    next_ck_q = 1'b1;
                    next_st = lsp_pkg::H_RHIGH;
                end
            end
            lsp_pkg::H_RHIGH: begin
                if (tick) begin
                    next_rx = {rx[6:0], dsync2}; // [RQ13]
                    next_ck_q = 1'b0;
                    next_left = left - 5'h01;
                    next_st = (left == 5'h01) ? lsp_pkg::H_IDLE : lsp_pkg::H_RLOW;
                end
            end
            default: next_st = lsp_pkg::H_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= lsp_pkg::H_IDLE;
            sh <= 24'h000000;
            left <= 5'h00;
            cs_q <= 1'b1;
            ck_q <= 1'b0;
            din_q <= 1'b0;
            rx <= 8'h00;
        end else begin
            st <= next_st;
            sh <= next_sh;
            left <= next_left;
            cs_q <= next_cs_q;
            ck_q <= next_ck_q;
            din_q <= next_din_q;
            rx <= next_rx;
        end
    end

    assign link.cs_n = cs_q;
    assign link.sclk = ck_q;
    assign link.din = din_q;
endmodule : lsp_host

/* lsp_link_sva.sv */
`timescale 1ns/100ps
module lsp_link_sva (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Link signals
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout_drv,
    input wire logic dout_oe,
    input wire logic dout_line
);
    // ********
    // Falls of the clock while deselected
    // ********
    logic [3:0] falls;
    logic [3:0] next_falls;
    logic sclk_d;
    always_comb begin
        next_falls = falls;
        if (!cs_n) begin
            next_falls = 4'h0;
        end else if (sclk_d && !sclk && falls != 4'hF) begin
            next_falls = falls + 4'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            falls <= 4'h0;
            sclk_d <= 1'b0;
        end else begin
            falls <= next_falls;
            sclk_d <= sclk;
        end
    end
    // ********
    // Properties
    // ********
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_high_half;
        sclk [*4] ##1 (!sclk || cs_n);
    endsequence
    sequence s_tail_half;
        sclk [*4] ##1 !sclk;
    endsequence
    sequence s_read_high;
        (dout_oe && sclk) [*2];
    endsequence
    chk_sel_clk_low: assert property ($fell(cs_n) |-> !sclk)
        else $error("select fell with clock high");
    chk_sel_rise_high: assert property ($rose(cs_n) |-> sclk)
        else $error("select rose with clock low");
    chk_din_held: assert property (!cs_n && sclk && $past(sclk) |-> $stable(din))
        else $error("data moved while clock high");
    chk_din_setup: assert property ($rose(sclk) && !cs_n |-> $stable(din))
        else $error("data moved at clock rise");
    chk_high_half: assert property ($rose(sclk) |-> s_high_half)
        else $error("clock high half wrong length");
    chk_tail_half: assert property ($rose(cs_n) |-> s_tail_half)
        else $error("clock not lowered after select rose");
    chk_oe_idle: assert property ((!cs_n) [*5] |-> !dout_oe)
        else $error("output driven while selected");
    chk_abort_rel: assert property ($fell(cs_n) |-> ##[0:4] !dout_oe)
        else $error("read-back not aborted");
    chk_eight_rel: assert property (falls == 4'h9 |-> ##[0:5] !dout_oe)
        else $error("output kept after eighth fall");
    chk_dout_held: assert property (s_read_high |-> $stable(dout_drv))
        else $error("read bit moved while clock high");
    chk_line_pull: assert property (!dout_oe |-> dout_line)
        else $error("released line not high");
endmodule : lsp_link_sva

/* testbench.sv */
`timescale 1ns/100ps
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic cfg_wr;
    logic [3:0] cfg_addr;
    logic [7:0] cfg_data;
    logic [7:0] cfg_data2;
    logic [13:0] disp_ptr;
    logic [7:0] rb;
    int mismatches = 0;
    int n_compared = 0;
    int n_cfg_wr = 0;
    lsp_link_if link ();
    lsp_link_if link2 ();
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (cfg_wr === 1'b1) begin
            n_cfg_wr++;
        end
    end
    lsp_host u_lsp_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .link(link));
    lsp_device u_lsp_device (.clk_i(clk_i), .rst_i(rst_i), .link(link), .pos_i(8'h00),
        .cfg_wr_o(cfg_wr), .cfg_addr_o(cfg_addr), .cfg_data_o(cfg_data), .disp_ptr_o(disp_ptr));
    lsp_device u_lsp_device_2 (.clk_i(clk_i), .rst_i(rst_i), .link(link2), .pos_i(8'h01),
        .cfg_wr_o(), .cfg_addr_o(), .cfg_data_o(cfg_data2), .disp_ptr_o());
    lsp_link_sva u_lsp_link_sva (.clk_i(clk_i), .rst_i(rst_i), .cs_n(link.cs_n),
        .sclk(link.sclk), .din(link.din), .dout_drv(link.dout_drv), .dout_oe(link.dout_oe),
        .dout_line(link.dout_line));
    // ********
    // Tasks
    // ********
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        @(posedge clk_i);
        while (ack !== 1'b1) begin
            @(posedge clk_i);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic frame(input logic [23:0] f, input logic [1:0] len, input logic rd);
        logic [31:0] q;
        wb(1'b1, lsp_pkg::HOST_FRAME, {8'h00, f}, q);
        wb(1'b1, lsp_pkg::HOST_CTRL, {23'h0, 1'b1, 3'h0, rd, 2'h0, len}, q);
        q = 32'h1;
        while (q[0] !== 1'b0) begin
            wb(1'b0, lsp_pkg::HOST_STATUS, 32'h0, q);
        end
        rb = q[15:8];
    endtask : frame
    task automatic tx(input logic [23:0] f, input int n);
        link2.cs_n <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int k = n - 1; k >= 0; k--) begin
            link2.din <= f[k];
            repeat (4) @(posedge clk_i);
            link2.sclk <= 1'b1;
            repeat (4) @(posedge clk_i);
            if (k > 0) begin
                link2.sclk <= 1'b0;
            end
        end
        link2.cs_n <= 1'b1;
        repeat (4) @(posedge clk_i);
        link2.sclk <= 1'b0;
        repeat (12) @(posedge clk_i);
    endtask : tx
    // ********
    // Tests
    // ********
    initial begin
        link2.cs_n = 1'b1;
        link2.sclk = 1'b0;
        link2.din = 1'b0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("ptr reset", disp_ptr, 32'h0);
        frame(24'h00225A, 2'h2, 1'h0);
        check("cfg_addr", cfg_addr, 32'h2);
        check("cfg_data", cfg_data, 32'h5A);
        frame(24'h002903, 2'h2, 1'h0);
        frame(24'h002A00, 2'h2, 1'h0);
        check("ptr set", disp_ptr, 32'h3);
        frame(24'h000077, 2'h1, 1'h0);
        check("ptr inc", disp_ptr, 32'h4);
        frame(24'h8003EE, 2'h3, 1'h1);
        check("rd24 a", rb, 32'h77);
        frame(24'h800300, 2'h3, 1'h1);
        check("rd24 b", rb, 32'h77);
        check("ptr kept", disp_ptr, 32'h4);
        frame(24'h0005C3, 2'h3, 1'h0);
        frame(24'h800500, 2'h3, 1'h1);
        check("wr24", rb, 32'hC3);
        frame(24'h002D02, 2'h2, 1'h0);
        frame(24'h0010A5, 2'h3, 1'h0);
        frame(24'h801000, 2'h3, 1'h1);
        check("two bpp", rb, 32'hA5);
        frame(24'h00C000, 2'h2, 1'h1);
        check("rd16 own", rb, 32'h0);
        frame(24'h008000, 2'h2, 1'h1);
        check("rd16 other", rb, 32'hFF);
        frame(24'h006233, 2'h2, 1'h0);
        frame(24'h00A800, 2'h2, 1'h1);
        check("drv ptr", rb, 32'h1);
        check("cfg pulses", n_cfg_wr, 32'h5);
        tx(24'h002211, 16);
        check("good frame", cfg_data2, 32'h11);
        tx(24'h002222, 17);
        check("17 bits", cfg_data2, 32'h11);
        tx(24'h003233, 16);
        check("bit 12", cfg_data2, 32'h11);
        tx(24'h00A800, 16);
        check("global rd", link2.dout_oe, 32'h0);
        tx(24'h002801, 16);
        check("drv ptr wr", cfg_data2, 32'h1);
        tx(24'h008000, 16);
        check("oe on", link2.dout_oe, 32'h1);
        link2.sclk <= 1'b1;
        repeat (4) @(posedge clk_i);
        link2.sclk <= 1'b0;
        repeat (4) @(posedge clk_i);
        link2.cs_n <= 1'b0;
        repeat (5) @(posedge clk_i);
        check("abort", link2.dout_oe, 32'h0);
        close_out();
    end
    initial begin
        repeat (30000) @(posedge clk_i);
        mismatches++;
        close_out();
    end
endmodule : testbench
